// ==== inp_pkg.sv ====
/*
 * Package for the interrupt nesting and priority block: register offsets,
 * field positions, reset values and source counts.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
`default_nettype none
package inp_pkg;
   localparam logic [31:0] NEST_CTRL_OFFSET   = 32'hffff0030;
   localparam logic [31:0] IN_SERVICE_OFFSET  = 32'hffff003c;
   localparam logic [31:0] FAST_VECTOR_OFFSET = 32'hffff011c;
   localparam logic [31:0] NORM_VECTOR_OFFSET = 32'hffff001c;
   localparam logic [31:0] VECTOR_BASE_OFFSET = 32'hffff0014;
   localparam logic [31:0] FAST_SRC_OFFSET    = 32'hffff0100;
   localparam int NORMAL_NEST_BIT  = 0;
   localparam int FAST_NEST_BIT    = 1;
   localparam int NEST_CTRL_WIDTH  = 2;
   localparam int LEVEL_COUNT      = 8;
   localparam int SOURCE_COUNT     = 20;
   localparam int SRC_CODE_WIDTH   = 5;
   localparam int SRC_CODE_LSB     = 2;
   localparam int BASE_LSB         = 7;
   localparam int BASE_WIDTH       = 16;
   localparam logic [1:0]  NEST_CTRL_RESET   = 2'h0;
   localparam logic [7:0]  IN_SERVICE_RESET  = 8'h00;
   localparam logic [15:0] VECTOR_BASE_RESET = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ     = 32'h00000000;
endpackage
`default_nettype wire

// ==== inp_pick_if.sv ====
/*
 * Carrier between the top and the priority picker: request levels in,
 * winning source out.
 * Assumes both ends use the package constants for widths.
 */
`default_nettype none
interface inp_pick_if;
   import inp_pkg::*;
   logic [SOURCE_COUNT-1:0]   active;
   logic [2:0]                level [SOURCE_COUNT];
   logic [LEVEL_COUNT-1:0]    blocked;
   logic                      prioritise;
   logic                      found;
   logic [SRC_CODE_WIDTH-1:0] code;
   logic [2:0]                codeLevel;
   modport top    (output active, level, blocked, prioritise, input found, code, codeLevel);
   modport picker (input active, level, blocked, prioritise, output found, code, codeLevel);
endinterface
`default_nettype wire

// ==== inp_picker.sv ====
/*
 * Priority picker: finds the winning active source, skipping blocked levels only when prioritising.
 * Assumes level 0 is the highest priority and lower source indices win ties.
 */
`default_nettype none
module inp_picker
   import inp_pkg::*;
(
   // Carrier.
   inp_pick_if.picker pk
);
   always_comb begin
      pk.found     = 1'b0;
      pk.code      = '0;
      pk.codeLevel = '0;
      for (int i = 0; i < SOURCE_COUNT; i++) begin
         if (pk.active[i] && !(pk.prioritise && pk.blocked[pk.level[i]])) begin
            if (!pk.found || (pk.prioritise && pk.level[i] < pk.codeLevel)) begin
               pk.found     = 1'b1;
               pk.code      = SRC_CODE_WIDTH'(i);
               pk.codeLevel = pk.level[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== inp_nesting.sv ====
/*
 * Interrupt nesting and priority logic with an Avalon-MM register slave.
 * Assumes sources are synchronous levels and per-source levels are inputs.
 * Level 0 is the highest priority and level 7 the lowest.
 */
// Chosen here: register access over Avalon-MM.
// Overview of operation
// - Control bit 0 enables normal nesting and priority.
// - Control bit 1 enables fast nesting and priority.
// - Both bits clear: deliver, never nest, ignore levels.
// - Without nesting, fast takes precedence over normal.
// - With bit 0 set, normal vector read sets in-service bit of level.
// - Set in-service bit blocks that level and lower.
// - Each status write clears lowest-index set bit.
// - Fast vector: zero, base, code, zero fields.
// - Fast vector code is lowest-index active fast source; with bit 1 set, highest-priority unblocked one.
`default_nettype none
module inp_nesting
   import inp_pkg::*;
(
   // Clock and reset.
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // Avalon-MM slave.
   input  wire logic [31:0]             address,
   input  wire logic                    read,
   input  wire logic                    write,
   input  wire logic [31:0]             writedata,
   input  wire logic [3:0]              byteenable,
   output var  logic [31:0]             readdata,
   output var  logic                    waitrequest,
   // Interrupt sources and their levels.
   input  wire logic [SOURCE_COUNT-1:0] normalSrc,
   input  wire logic [SOURCE_COUNT-1:0] fastSrc,
   input  wire logic [3*SOURCE_COUNT-1:0] srcLevel,
   // Requests to the core.
   output var  logic                    normalReq,
   output var  logic                    fastReq
);
   typedef enum logic [0:0] {IDLE, DONE} inp_bus_e;
   inp_bus_e busState;
   logic [NEST_CTRL_WIDTH-1:0] nestCtrl;
   logic [LEVEL_COUNT-1:0]     inService;
   logic [BASE_WIDTH-1:0]      vectorBase;
   logic [LEVEL_COUNT-1:0]     blockMask;
   logic [LEVEL_COUNT-1:0]     lowestSet;
   logic [31:0]                next_readdata;
   logic                       access;
   logic                       takeEdge;
   logic                       normalNest;
   logic                       fastNest;
   logic [2:0]                 topLevel;
   logic                       hitCtrl;
   logic                       hitStatus;
   logic                       hitNormVec;
   logic                       hitFastVec;

   // Refuse package values that the fields, masks and codes cannot carry.
   if (SOURCE_COUNT > (1 << SRC_CODE_WIDTH)) begin : g_code_check
      $error("Source code field is too narrow for the source count.");
   end
   if (LEVEL_COUNT != 8) begin : g_level_check
      $error("Level fields are three bits wide and need eight levels.");
   end
   if (SRC_CODE_LSB + SRC_CODE_WIDTH != BASE_LSB) begin : g_field_check
      $error("Source code field must sit directly below the base field.");
   end
   if (BASE_LSB + BASE_WIDTH != 23) begin : g_base_check
      $error("Base field must end just below the zero field at bit 23.");
   end
   if (NEST_CTRL_WIDTH != 2 || FAST_NEST_BIT != 1 || NORMAL_NEST_BIT != 0) begin : g_ctrl_check
      $error("Control register must hold exactly the two nesting bits.");
   end

   inp_pick_if normPick ();
   inp_pick_if fastPick ();

   inp_picker u_norm (.pk(normPick.picker));
   inp_picker u_fast (.pk(fastPick.picker));

   assign normalNest = nestCtrl[NORMAL_NEST_BIT];
   assign fastNest   = nestCtrl[FAST_NEST_BIT];
   assign access     = read | write;
   assign takeEdge   = access && busState == IDLE;
   assign hitCtrl    = address == NEST_CTRL_OFFSET;
   assign hitStatus  = address == IN_SERVICE_OFFSET;
   assign hitNormVec = address == NORM_VECTOR_OFFSET;
   assign hitFastVec = address == FAST_VECTOR_OFFSET;

   // Blocks each set level and every lower-priority, higher-numbered level.
   always_comb begin
      blockMask = '0;
      for (int b = 0; b < LEVEL_COUNT; b++) begin
         for (int l = b; l < LEVEL_COUNT; l++) begin
            if (inService[b]) begin
               blockMask[l] = 1'b1;
            end
         end
      end
   end

   always_comb begin
      lowestSet = inService & (~inService + 8'h01);
   end

   // Highest-priority level in service, worked out apart from the masks for the checks.
   always_comb begin
      topLevel = 3'h7;
      for (int b = LEVEL_COUNT - 1; b >= 0; b--) begin
         if (inService[b]) topLevel = 3'(b);
      end
   end

   always_comb begin
      normPick.active     = normalSrc;
      fastPick.active     = fastSrc;
      normPick.blocked    = blockMask;
      fastPick.blocked    = blockMask;
      normPick.prioritise = normalNest;
      fastPick.prioritise = fastNest;
      for (int s = 0; s < SOURCE_COUNT; s++) begin
         normPick.level[s] = srcLevel[3*s +: 3];
         fastPick.level[s] = srcLevel[3*s +: 3];
      end
   end

   // Bus handshake: one wait cycle, answer on the second edge.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busState <= IDLE;
      end else if (takeEdge) begin
         busState <= DONE;
      end else begin
         busState <= IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !takeEdge;
      end
   end

   always_comb begin
      next_readdata = UNMAPPED_READ;
      case (address)
         NEST_CTRL_OFFSET:   next_readdata = {30'h0, nestCtrl};
         IN_SERVICE_OFFSET:  next_readdata = {24'h0, inService};
         VECTOR_BASE_OFFSET: next_readdata = {16'h0, vectorBase};
         NORM_VECTOR_OFFSET: next_readdata = {9'h0, vectorBase, normPick.code, 2'h0};
         FAST_VECTOR_OFFSET: next_readdata = {9'h0, vectorBase, fastPick.code, 2'h0};
         default:            next_readdata = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         readdata <= '0;
      end else if (takeEdge && read) begin
         readdata <= next_readdata;
      end
   end

   // Reserved upper bits are dropped on write.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         nestCtrl <= NEST_CTRL_RESET;
      end else if (takeEdge && write && address == NEST_CTRL_OFFSET && byteenable[0]) begin
         nestCtrl <= writedata[NEST_CTRL_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         vectorBase <= VECTOR_BASE_RESET;
      end else if (takeEdge && write && address == VECTOR_BASE_OFFSET) begin
         if (byteenable[0]) vectorBase[7:0]  <= writedata[7:0];
         if (byteenable[1]) vectorBase[15:8] <= writedata[15:8];
      end
   end

   // A vector read that records a level wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         inService <= IN_SERVICE_RESET;
      end else if (takeEdge && read && address == NORM_VECTOR_OFFSET
                   && normalNest && normPick.found) begin
         inService <= inService | (8'h01 << normPick.codeLevel);
      end else if (takeEdge && write && address == IN_SERVICE_OFFSET) begin
         inService <= inService & ~lowestSet;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fastReq <= 1'b0;
      end else begin
         fastReq <= fastPick.found;
      end
   end

   // Fast precedence: a normal request is held off while a fast one stands.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         normalReq <= 1'b0;
      end else begin
         normalReq <= normPick.found && !fastPick.found;
      end
   end

   // Bus handshake steps used by the bus release check.
   sequence s_bus_taken;
      takeEdge;
   endsequence

   sequence s_bus_answer;
      !waitrequest ##1 waitrequest;
   endsequence

   // A normal vector read that records a level while nesting is on.
   sequence s_vector_take;
      takeEdge && read && hitNormVec && normalNest && normPick.found;
   endsequence

   // A status write taken while some level is in service.
   sequence s_status_clear;
      takeEdge && write && hitStatus && |inService;
   endsequence

   // Cycles that a request has waited, so that the latency check stays a bound.
   logic [1:0] waitCount;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         waitCount <= 2'h0;
      end else if (access && waitrequest) begin
         waitCount <= waitCount + 2'h1;
      end else begin
         waitCount <= 2'h0;
      end
   end

   // Status register checks.
   a_status_clear_one: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && write && hitStatus) |=> $countones($past(inService))
      - $countones(inService) == ($past(inService) != 0))
      else $error("status write cleared wrong count");

   a_clear_lowest: assert property (@(posedge clk) disable iff (!nrst)
      s_status_clear |=> inService == ($past(inService) & ~(8'h01 << $past(topLevel))))
      else $error("status write cleared a lower-priority bit");

   a_level_set: assert property (@(posedge clk) disable iff (!nrst)
      s_vector_take |=> inService[$past(normPick.codeLevel)])
      else $error("level bit not set");

   a_level_only: assert property (@(posedge clk) disable iff (!nrst)
      s_vector_take |=> (inService ^ $past(inService))
      == ((8'h01 << $past(normPick.codeLevel)) & ~$past(inService)))
      else $error("vector read changed another level bit");

   a_no_nest_set: assert property (@(posedge clk) disable iff (!nrst)
      (!normalNest && !(takeEdge && write && hitCtrl))
      |=> !$rose(|inService)) else $error("status set without nesting");

   // Blocking and priority checks.
   a_block_nested: assert property (@(posedge clk) disable iff (!nrst)
      (fastNest && fastPick.found) |-> !blockMask[fastPick.codeLevel])
      else $error("blocked level forwarded");

   a_norm_above: assert property (@(posedge clk) disable iff (!nrst)
      (normalNest && normPick.found && |inService) |-> normPick.codeLevel < topLevel)
      else $error("normal level not above in-service levels");

   a_fast_above: assert property (@(posedge clk) disable iff (!nrst)
      (fastNest && fastPick.found && |inService) |-> fastPick.codeLevel < topLevel)
      else $error("fast level not above in-service levels");

   a_fast_first: assert property (@(posedge clk) disable iff (!nrst)
      fastReq |-> !normalReq) else $error("normal request beside fast");

   a_fast_wins: assert property (@(posedge clk) disable iff (!nrst)
      fastPick.found |=> fastReq && !normalReq)
      else $error("fast source did not take precedence");

   a_fast_plain: assert property (@(posedge clk) disable iff (!nrst)
      (!fastNest && |fastSrc) |=> fastReq) else $error("fast not delivered");

   a_plain_deliver: assert property (@(posedge clk) disable iff (!nrst)
      (!normalNest && |normalSrc && !(|fastSrc)) |=> normalReq)
      else $error("normal not delivered without nesting");

   // Register read and store checks.
   a_vector_fields: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && read && hitFastVec) |=>
      readdata[31:23] == 9'h0 && readdata[1:0] == 2'h0
      && readdata[22:7] == $past(vectorBase)) else $error("fast vector layout");

   a_vector_code: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && read && hitFastVec) |=> readdata[6:2] == $past(fastPick.code))
      else $error("fast vector code field");

   a_code_range: assert property (@(posedge clk) disable iff (!nrst)
      fastPick.found |-> fastPick.code < SRC_CODE_WIDTH'(SOURCE_COUNT))
      else $error("fast code out of range");

   a_base_store: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && write && address == VECTOR_BASE_OFFSET && byteenable[1:0] == 2'h3)
      |=> vectorBase == $past(writedata[15:0])) else $error("vector base not stored");

   a_ctrl_store: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && write && hitCtrl && byteenable[0]) |=>
      nestCtrl == $past(writedata[1:0])) else $error("control not stored");

   a_ctrl_hold: assert property (@(posedge clk) disable iff (!nrst)
      !(takeEdge && write && hitCtrl) |=> $stable(nestCtrl))
      else $error("control changed without a write");

   a_ctrl_zeros: assert property (@(posedge clk) disable iff (!nrst)
      (takeEdge && read && hitCtrl) |=> readdata[31:2] == 30'h0)
      else $error("control reserved bits not zero");

   // Bus handshake checks.
   a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
      $rose(access) |-> waitrequest ##1 !waitrequest) else $error("bus answer late");

   a_bus_release: assert property (@(posedge clk) disable iff (!nrst)
      s_bus_taken |=> s_bus_answer) else $error("wait state not one cycle");

   a_idle_wait: assert property (@(posedge clk) disable iff (!nrst)
      !access |=> waitrequest) else $error("waitrequest low while idle");

   a_wait_bound: assert property (@(posedge clk) disable iff (!nrst)
      waitCount < 2'h2) else $error("request waited too long");

   a_read_hold: assert property (@(posedge clk) disable iff (!nrst)
      !(takeEdge && read) |=> $stable(readdata)) else $error("read data moved");
endmodule
`default_nettype wire

// ==== inp_core_model.sv ====
/*
 * Core model: takes the request levels and shows which kind it serves.
 * Assumes requests are registered levels on the same clock.
 */
`default_nettype none
module inp_core_model (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       nrst,
   // Requests from the block.
   input  wire logic       normalReq,
   input  wire logic       fastReq,
   // Kind in service: 0 none, 1 normal, 2 fast.
   output var  logic [1:0] serving
);
   always_ff @(posedge clk) begin
      if (!nrst) serving <= 2'h0;
      else if (fastReq) serving <= 2'h2;
      else if (normalReq) serving <= 2'h1;
      else serving <= 2'h0;
   end
endmodule
`default_nettype wire

// ==== tb_interrupt_nesting_priority.sv ====
/*
 * Self-checking bench for the nesting and priority block.
 * Assumes one wait state per register access and registered requests.
 */
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_interrupt_nesting_priority;
   import inp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, nrst = 0, read = 0, write = 0, normalReq, fastReq, waitrequest;
   logic [31:0] address = 0, writedata = 0, readdata, q;
   logic [3:0]  byteenable = 4'hf;
   logic [19:0] normalSrc = 0, fastSrc = 0;
   logic [59:0] srcLevel = 0;
   logic [1:0]  serving;
   int          err_count = 0, compares = 0;
   always #25 clk = ~clk;
   inp_nesting inp_nesting_inst (.clk(clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .normalSrc(normalSrc), .fastSrc(fastSrc),
      .srcLevel(srcLevel), .normalReq(normalReq), .fastReq(fastReq));
   inp_core_model inp_core_model_inst (.clk(clk), .nrst(nrst), .normalReq(normalReq),
      .fastReq(fastReq), .serving(serving));
   function automatic logic [59:0] lv(input int s, input logic [2:0] l);
      return 60'(l) << (3 * s);
   endfunction
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic src(input logic [19:0] n, input logic [19:0] f, input logic [59:0] l);
      normalSrc <= n;
      fastSrc <= f;
      srcLevel <= l;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_reset;
      bus(0, NEST_CTRL_OFFSET, 0); `CHK("ctrl", 32'h0, q)
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h0, q)
      bus(0, 32'hffff0ff0, 0); `CHK("unmapped", 32'h0, q)
   endtask
   task automatic t_plain;
      src(20'h208, 20'h20, lv(9, 3'h7) | lv(3, 3'h1));
      `CHK("both", 2'h2, {fastReq, normalReq})
      `CHK("serve", 2'h2, serving)
      bus(0, NORM_VECTOR_OFFSET, 0); `CHK("nvec", 32'h0c, q)
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h0, q)
   endtask
   task automatic t_nest;
      src(0, 0, 0);
      bus(1, NEST_CTRL_OFFSET, 32'h1);
      bus(0, NEST_CTRL_OFFSET, 0); `CHK("ctrl", 32'h1, q)
      src(20'h4, 0, lv(2, 3'h3));
      bus(0, NORM_VECTOR_OFFSET, 0); `CHK("nvec", 32'h08, q)
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h08, q)
      `CHK("blocked", 1'b0, normalReq)
      src(20'h16, 0, lv(1, 3'h3) | lv(2, 3'h3) | lv(4, 3'h1));
      `CHK("higher", 1'b1, normalReq)
      bus(0, NORM_VECTOR_OFFSET, 0); `CHK("nvec", 32'h10, q)
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h0a, q)
      `CHK("blocked", 1'b0, normalReq)
   endtask
   task automatic t_clear;
      bus(1, IN_SERVICE_OFFSET, 32'hff);
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h08, q)
      bus(1, IN_SERVICE_OFFSET, 32'hff);
      bus(0, IN_SERVICE_OFFSET, 0); `CHK("insvc", 32'h0, q)
      `CHK("free", 1'b1, normalReq)
   endtask
   task automatic t_fast;
      bus(1, NEST_CTRL_OFFSET, 32'h2);
      bus(1, VECTOR_BASE_OFFSET, 32'h1234);
      src(0, 20'h1080, lv(7, 3'h2) | lv(12, 3'h6));
      `CHK("fast", 1'b1, fastReq)
      bus(0, FAST_VECTOR_OFFSET, 0);
      `CHK("fvec", {9'h0, 16'h1234, 5'd7, 2'h0}, q)
   endtask
   task automatic print_verdict;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset;
      t_plain;
      t_nest;
      t_clear;
      t_fast;
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict;
   end
endmodule
`undef CHK
`default_nettype wire
